// file: cpmo_core.sv
// Preset and match compare logic of one high-speed counter channel.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] A preset value write only updates the stored preset, not the count.
// [R2] A rising edge of preset_cmd copies the stored preset into the count.
// [R3] Preset loads happen whether or not counting is enabled.
// [R4] Software should use preset_cmd when no index or counter function presets.
// [R5] Two independent match points, each with match, above and below flags.
// [R6] below_flag_1 is on while count is less than match point 1.
// [R7] above_flag_1 is on while count is greater than match point 1.
// [R8] Count equal to match point 1 sets match_flag_1 and match output 1.
// [R9] match_clear_cmd_1 forces match_flag_1 and output 1 off.
// [R10] Releasing the clear while still equal sets the flag and output again.
// [R11] A match flag stays latched until its clear command.
// [R12] The match event is the rising edge of the match flag.
// [R13] Match outputs drive only while match_output_enable_cmd is on.
// [R14] Match flags set regardless of the output enable.
// [R15] Above or below may overlap the match flag in the same interval.
// [R16] Software holds each match clear on for at least 2 ms.
// [R17] With preset on match, a rise of match_flag_1 loads the preset.
// [R18] A rise of match_flag_2 never causes a preset.
// [R19] A preset on match uses the latest written preset value.
// [R20] Without a clear, a repeated equality loads nothing since no rise occurs.
// [R21] While ext_index_preset_flag is on, all preset loads are blocked.
// [R22] Software leaves 2 ms between a preset write and the load.
// [R23] The count is signed 32 bits, saturating at its limits.
// [R24] Flags are re-evaluated every cycle after any change of the count.
module cpmo_core
  import cpmo_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [CPMO_AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_cnt_inc,
  input wire logic i_cnt_dec,
  input wire logic i_index_preset_set,
  output logic signed [31:0] o_count_value,
  output logic o_count_enable,
  output cpmo_status_t o_status,
  output logic [1:0] o_match_out,
  output logic [1:0] o_match_event
);

  // ****************************************
  // Compare function
  // ****************************************
  // [R6] [R7] [R8] Below, match and above of one point.
  function automatic cpmo_cmp_t cpmo_compare(
    input logic signed [31:0] cnt,
    input logic signed [31:0] pt
  );
    cpmo_cmp_t r;
    r.below = (cnt < pt);
    r.match = (cnt == pt);
    r.above = (cnt > pt);
    return r;
  endfunction : cpmo_compare

  // ****************************************
  // Declarations
  // ****************************************
  cpmo_ctrl_t ctrl_reg;
  cpmo_ctrl_t ctrl_next;
  logic signed [31:0] preset_val_reg;
  logic signed [31:0] mp1_reg;
  logic signed [31:0] mp2_reg;
  logic signed [31:0] count_reg;
  logic signed [31:0] count_next;
  cpmo_cmp_t cmp1_reg;
  cpmo_cmp_t cmp2_reg;
  cpmo_cmp_t cmp1_next;
  cpmo_cmp_t cmp2_next;
  cpmo_cmp_t rel1;
  cpmo_cmp_t rel2;
  logic preset_d_reg;
  logic m1_d_reg;
  logic idx_flag_reg;
  logic idx_flag_next;
  logic [1:0] out_reg;
  logic [1:0] evt_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  cpmo_status_t status;
  wire wr_ctrl;
  wire wr_preset;
  wire wr_mp1;
  wire wr_mp2;
  wire preset_rise;
  wire m1_rise;
  wire m2_rise;
  wire preset_req;
  wire preset_go;
  wire step_up;
  wire step_dn;
  wire any_step;

  // ****************************************
  // Register bus decode
  // ****************************************
  assign wr_ctrl = i_wr & (i_addr == CPMO_ADDR_CTRL);
  assign wr_preset = i_wr & (i_addr == CPMO_ADDR_PRESET);
  assign wr_mp1 = i_wr & (i_addr == CPMO_ADDR_MATCH1);
  assign wr_mp2 = i_wr & (i_addr == CPMO_ADDR_MATCH2);
  assign ctrl_next = wr_ctrl ? cpmo_ctrl_t'(i_wdata[CPMO_CTRL_W-1:0])
                             : ctrl_reg;

  assign status = '{ext_index_preset_flag: idx_flag_reg,
                    pt2: cmp2_reg, pt1: cmp1_reg};

  assign rd_mux =
    (i_addr == CPMO_ADDR_CTRL) ? {25'h0000000, ctrl_reg} :
    (i_addr == CPMO_ADDR_PRESET) ? preset_val_reg :
    (i_addr == CPMO_ADDR_MATCH1) ? mp1_reg :
    (i_addr == CPMO_ADDR_MATCH2) ? mp2_reg :
    (i_addr == CPMO_ADDR_CNT_LO) ? {16'h0000, count_reg[15:0]} :
    (i_addr == CPMO_ADDR_CNT_HI) ? {16'h0000, count_reg[31:16]} :
    (i_addr == CPMO_ADDR_STATUS) ? {25'h0000000, status} :
    CPMO_WORD_RST;

  // ****************************************
  // Preset and count path
  // ****************************************
  // [R2] Preset command edge.
  assign preset_rise = ctrl_reg.preset_cmd & ~preset_d_reg;
  // [R12] [R20] Match flag edges, none while a flag stays latched.
  assign m1_rise = cmp1_reg.match & ~m1_d_reg;
  // [R18] Point 2 rise is watched but never feeds a preset.
  assign m2_rise = evt_reg[1];
  // [R17] [R18] Preset on match from point 1 only.
  assign preset_req = preset_rise | (ctrl_reg.preset_on_match & m1_rise);
  // [R21] Index flag blocks every preset.
  assign preset_go = preset_req & ~idx_flag_reg;
  // [R23] Saturating count steps.
  assign step_up = ctrl_reg.count_enable_cmd & i_cnt_inc & ~i_cnt_dec &
                   (count_reg != CPMO_CNT_MAX);
  assign step_dn = ctrl_reg.count_enable_cmd & i_cnt_dec & ~i_cnt_inc &
                   (count_reg != CPMO_CNT_MIN);
  assign any_step = step_up | step_dn;
  // [R3] [R19] Preset wins over counting, using the stored value.
  assign count_next = preset_go ? preset_val_reg :
                      step_up ? count_reg + CPMO_CNT_ONE :
                      step_dn ? count_reg - CPMO_CNT_ONE :
                      count_reg;

  // ****************************************
  // Compare path
  // ****************************************
  // [R5] [R24] Both points compared against the count each cycle.
  assign rel1 = cpmo_compare(count_reg, mp1_reg);
  assign rel2 = cpmo_compare(count_reg, mp2_reg);
  // [R9] [R10] [R11] [R15] Latched match, cleared while clear is on.
  assign cmp1_next = '{below: rel1.below, above: rel1.above,
    match: ~ctrl_reg.match_clear_cmd_1 & (cmp1_reg.match | rel1.match)};
  assign cmp2_next = '{below: rel2.below, above: rel2.above,
    match: ~ctrl_reg.match_clear_cmd_2 & (cmp2_reg.match | rel2.match)};
  // [R21] Index flag set wins over its clear.
  assign idx_flag_next = i_index_preset_set |
    (idx_flag_reg & ~ctrl_reg.ext_index_preset_flag_clear);

  // ****************************************
  // Registers
  // ****************************************
  // [R1] Preset value write touches only the stored preset.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= CPMO_CTRL_RST;
      preset_val_reg <= CPMO_WORD_RST;
      mp1_reg <= CPMO_WORD_RST;
      mp2_reg <= CPMO_WORD_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      preset_val_reg <= wr_preset ? i_wdata : preset_val_reg;
      mp1_reg <= wr_mp1 ? i_wdata : mp1_reg;
      mp2_reg <= wr_mp2 ? i_wdata : mp2_reg;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= CPMO_WORD_RST;
      cmp1_reg <= '0;
      cmp2_reg <= '0;
      preset_d_reg <= 1'b0;
      m1_d_reg <= 1'b0;
      idx_flag_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      cmp1_reg <= cmp1_next;
      cmp2_reg <= cmp2_next;
      preset_d_reg <= ctrl_reg.preset_cmd;
      m1_d_reg <= cmp1_reg.match;
      idx_flag_reg <= idx_flag_next;
    end
  end

  // [R13] [R14] Outputs gated by the enable, events on flag rise.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_reg <= 2'h0;
      evt_reg <= 2'h0;
      rdata_reg <= CPMO_WORD_RST;
    end else begin
      out_reg <= {cmp2_next.match, cmp1_next.match} &
                 {2{ctrl_reg.match_output_enable_cmd}};
      evt_reg <= {cmp2_next.match & ~cmp2_reg.match,
                  cmp1_next.match & ~cmp1_reg.match};
      rdata_reg <= i_rd ? rd_mux : CPMO_WORD_RST;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_count_value = count_reg;
  assign o_count_enable = ctrl_reg.count_enable_cmd;
  assign o_status = status;
  assign o_match_out = out_reg;
  assign o_match_event = evt_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_preset_write;
    wr_preset;
  endsequence

  sequence s_match_load;
    ctrl_reg.preset_on_match && m1_rise && !idx_flag_reg;
  endsequence

  sequence s_clear_release;
    ctrl_reg.match_clear_cmd_1 ##1 !ctrl_reg.match_clear_cmd_1;
  endsequence

  // [R1] Preset write keeps the count.
  chk_preset_write: assert property ( // [R1]
    wr_preset && !preset_go && !any_step |=>
      preset_val_reg == $past(i_wdata) && $stable(count_reg))
    else $error("preset write wrong");

  // [R2] Preset command load.
  chk_preset_cmd: assert property ( // [R2]
    preset_rise && !idx_flag_reg |=>
      count_reg == $past(preset_val_reg))
    else $error("preset command did not load");

  // [R3] Preset beats counting.
  chk_preset_enable: assert property ( // [R3]
    preset_go && ctrl_reg.count_enable_cmd && i_cnt_inc |=>
      count_reg == $past(preset_val_reg))
    else $error("preset lost to counting");

  // [R6] Below flag tracks count.
  chk_below_flag: assert property ( // [R6]
    ##1 cmp1_reg.below == ($past(count_reg) < $past(mp1_reg)))
    else $error("below flag wrong");

  // [R7] Above flag tracks count.
  chk_above_flag: assert property ( // [R7]
    ##1 cmp1_reg.above == ($past(count_reg) > $past(mp1_reg)))
    else $error("above flag wrong");

  // [R8] Equality sets flag and output.
  chk_match_set: assert property ( // [R8]
    count_reg == mp1_reg && !ctrl_reg.match_clear_cmd_1 &&
    ctrl_reg.match_output_enable_cmd |=>
      cmp1_reg.match && o_match_out[0])
    else $error("match not set");

  // [R9] Clear forces flag and output off.
  chk_clear_force: assert property ( // [R9]
    ctrl_reg.match_clear_cmd_1 |=> !cmp1_reg.match && !o_match_out[0])
    else $error("clear did not force off");

  // [R10] Release while equal sets again.
  chk_clear_release: assert property ( // [R10]
    s_clear_release ##0 count_reg == mp1_reg |=> cmp1_reg.match)
    else $error("match not set after release");

  // [R11] Flag latched until clear.
  chk_match_latch: assert property ( // [R11]
    cmp2_reg.match && !ctrl_reg.match_clear_cmd_2 |=> cmp2_reg.match)
    else $error("match flag not latched");

  // [R12] Event only on the rising edge.
  chk_event_edge: assert property ( // [R12]
    o_match_event[0] == (cmp1_reg.match && !$past(cmp1_reg.match)))
    else $error("event not on rising edge");

  // [R13] Outputs need the enable.
  chk_output_gate: assert property ( // [R13]
    ##1 o_match_out == ({cmp2_reg.match, cmp1_reg.match} &
      {2{$past(ctrl_reg.match_output_enable_cmd)}}))
    else $error("output gating wrong");

  // [R14] Flag sets without the enable.
  chk_flag_indep: assert property ( // [R14]
    i_resetn && count_reg == mp2_reg && !ctrl_reg.match_clear_cmd_2 &&
    !ctrl_reg.match_output_enable_cmd |=>
      cmp2_reg.match && !o_match_out[1])
    else $error("flag depends on enable");

  // [R17] Preset on match load.
  chk_match_preset: assert property ( // [R17]
    s_match_load |=> count_reg == $past(preset_val_reg))
    else $error("preset on match missing");

  // [R18] Point 2 never presets.
  chk_no_pt2_preset: assert property ( // [R18]
    m2_rise && !preset_rise && !m1_rise && !any_step |=>
      $stable(count_reg))
    else $error("point 2 caused a change");

  // [R19] Latest written preset is used.
  chk_recent_value: assert property ( // [R19]
    s_preset_write ##1 s_match_load |=>
      count_reg == $past(i_wdata, 2))
    else $error("stale preset loaded");

  // [R20] No rise, no load.
  chk_no_rise: assert property ( // [R20]
    m1_d_reg && cmp1_reg.match && !preset_rise && !any_step |=>
      $stable(count_reg))
    else $error("load without rise");

  // [R21] Index flag blocks loads and clears.
  chk_index_block: assert property ( // [R21]
    idx_flag_reg && !any_step |=> $stable(count_reg))
    else $error("preset while blocked");

  chk_index_clear: assert property ( // [R21]
    idx_flag_reg && ctrl_reg.ext_index_preset_flag_clear &&
    !i_index_preset_set |=> !idx_flag_reg)
    else $error("index flag not cleared");

  // [R23] Count saturates at the top.
  chk_count_sat: assert property ( // [R23]
    count_reg == CPMO_CNT_MAX && !preset_go |=> count_reg != CPMO_CNT_MIN)
    else $error("count wrapped");

  // [R24] Flags follow a count change.
  chk_flag_track: assert property ( // [R24]
    $changed(count_reg) |=>
      cmp2_reg.below == ($past(count_reg) < $past(mp2_reg)) &&
      cmp2_reg.above == ($past(count_reg) > $past(mp2_reg)))
    else $error("flags stale after change");

  // [R3] Preset with counting off.
  chk_preset_idle: assert property ( // [R3]
    preset_go && !ctrl_reg.count_enable_cmd |=>
      count_reg == $past(preset_val_reg))
    else $error("preset lost with counting off");

  // [R5] Point 2 equality sets flag and output.
  chk_match_two: assert property ( // [R5]
    count_reg == mp2_reg && !ctrl_reg.match_clear_cmd_2 &&
    ctrl_reg.match_output_enable_cmd |=>
      cmp2_reg.match && o_match_out[1])
    else $error("point 2 match not set");

  // [R5] Point 2 clear forces flag and output off.
  chk_clear_two: assert property ( // [R5]
    ctrl_reg.match_clear_cmd_2 |=> !cmp2_reg.match && !o_match_out[1])
    else $error("point 2 clear did not force off");

  // [R12] Point 2 event only on the rising edge.
  chk_event_two: assert property ( // [R12]
    o_match_event[1] == (cmp2_reg.match && !$past(cmp2_reg.match)))
    else $error("point 2 event not on rising edge");

  // [R19] Stored preset keeps the last write.
  chk_preset_hold: assert property ( // [R19]
    !wr_preset |=> $stable(preset_val_reg))
    else $error("stored preset changed without a write");

  // [R23] Count saturates at the bottom.
  chk_count_floor: assert property ( // [R23]
    count_reg == CPMO_CNT_MIN && !preset_go |=> count_reg != CPMO_CNT_MAX)
    else $error("count wrapped below");

endmodule : cpmo_core

`default_nettype wire

// file: cpmo_core_tb.sv
// Self-checking bench of the preset and match block.
`timescale 1ns/1ps
`default_nettype none
module cpmo_core_tb;
  import cpmo_pkg::*;
  logic i_ref_clk;
  logic i_resetn;
  logic [CPMO_AW-1:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic i_cnt_inc;
  logic i_cnt_dec;
  logic i_index_preset_set;
  logic signed [31:0] o_count_value;
  logic o_count_enable;
  cpmo_status_t o_status;
  logic [1:0] o_match_out;
  logic [1:0] o_match_event;
  logic [7:0] rise_0;
  logic [7:0] rise_1;
  logic [31:0] rd_val;
  int err_total;
  int checked;
  int ev_0;
  int ev_1;
  int cycles;

  cpmo_core u_cpmo_core (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_cnt_inc(i_cnt_inc), .i_cnt_dec(i_cnt_dec),
    .i_index_preset_set(i_index_preset_set),
    .o_count_value(o_count_value), .o_count_enable(o_count_enable),
    .o_status(o_status), .o_match_out(o_match_out),
    .o_match_event(o_match_event));
  cpmo_load u_cpmo_load (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_match_out(o_match_out), .o_rise_0(rise_0), .o_rise_1(rise_1));

  // ****************************************
  // Clock, event count and time limit
  // ****************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (o_match_event[0] === 1'b1) begin
      ev_0 <= ev_0 + 1;
    end
    if (o_match_event[1] === 1'b1) begin
      ev_1 <= ev_1 + 1;
    end
    if (cycles == 3000) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: time limit reached", $time);
      complete_run();
    end
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : chk

  task automatic wr(input logic [CPMO_AW-1:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [CPMO_AW-1:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : wt

  task automatic step(input int n, input logic up);
    repeat (n) begin
      @(posedge i_ref_clk);
      i_cnt_inc <= up;
      i_cnt_dec <= ~up;
      @(posedge i_ref_clk);
      i_cnt_inc <= 1'b0;
      i_cnt_dec <= 1'b0;
    end
    wt(4);
  endtask : step

  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask : tdone

  task automatic sat(input logic [31:0] v, input logic up,
                     input logic [5:0] st);
    wr(CPMO_ADDR_CTRL, 32'h1e);
    wr(CPMO_ADDR_PRESET, v);
    wr(CPMO_ADDR_CTRL, 32'h1f);
    step(1, up);
    chk(o_count_value, v, "count limit");
    chk({26'h0, o_status[5:0]}, {26'h0, st}, "signed compare");
  endtask : sat

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    err_total = 0;
    checked = 0;
    ev_0 = 0;
    ev_1 = 0;
    cycles = 0;
    i_resetn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_cnt_inc = 1'b0;
    i_cnt_dec = 1'b0;
    i_index_preset_set = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    wt(4);
    rd(CPMO_ADDR_STATUS, rd_val);
    chk(rd_val, 32'h12, "status after reset");
    wt(1);
    chk(o_rdata, 32'h0, "read data one cycle only");
    chk(32'(o_match_out), 32'h0, "outputs disabled");
    chk(32'(o_count_enable), 32'h0, "counting off");
    rd(CPMO_ADDR_CTRL, rd_val);
    chk(rd_val, 32'h0, "control reset");
    rd(8'h1c, rd_val);
    chk(rd_val, 32'h0, "unmapped read");
    tdone("reset");
    wr(CPMO_ADDR_PRESET, 32'h100);
    wt(4);
    chk(o_count_value, 32'h0, "count kept");
    wr(CPMO_ADDR_CTRL, 32'h01);
    wt(4);
    chk(o_count_value, 32'h100, "preset load");
    step(1, 1'b1);
    chk(o_count_value, 32'h100, "no step while disabled");
    rd(CPMO_ADDR_CNT_LO, rd_val);
    chk(rd_val, 32'h100, "count low word");
    rd(CPMO_ADDR_CNT_HI, rd_val);
    chk(rd_val, 32'h0, "count high word");
    tdone("preset");
    wr(CPMO_ADDR_MATCH1, 32'h102);
    wr(CPMO_ADDR_MATCH2, 32'hfffffffb);
    wr(CPMO_ADDR_CTRL, 32'h06);
    wr(CPMO_ADDR_CTRL, 32'h18);
    wt(4);
    chk(32'(o_status), 32'h0c, "below one above two");
    chk(32'(o_count_enable), 32'h1, "counting on");
    step(2, 1'b1);
    chk(32'(o_status), 32'h0a, "match one");
    chk(32'(o_match_out), 32'h1, "output one");
    chk(ev_0, 2, "match event");
    step(1, 1'b1);
    chk(32'(o_status), 32'h0b, "latched with above");
    step(1, 1'b0);
    chk(ev_0, 2, "no second event");
    wr(CPMO_ADDR_CTRL, 32'h1a);
    wt(4);
    chk(32'(o_status), 32'h08, "clear while equal");
    chk(32'(o_match_out), 32'h0, "output cleared");
    wr(CPMO_ADDR_CTRL, 32'h18);
    wt(4);
    chk(32'(o_status), 32'h0a, "match again");
    chk(ev_0, 3, "event again");
    chk(32'(rise_0), 32'h2, "load turned on twice");
    tdone("compare");
    wr(CPMO_ADDR_PRESET, 32'h50);
    wr(CPMO_ADDR_CTRL, 32'h5a);
    wr(CPMO_ADDR_CTRL, 32'h58);
    wt(4);
    chk(o_count_value, 32'h50, "preset on match");
    wr(CPMO_ADDR_MATCH1, 32'h51);
    step(1, 1'b1);
    chk(o_count_value, 32'h51, "no rise no load");
    wr(CPMO_ADDR_MATCH2, 32'h52);
    step(1, 1'b1);
    chk(o_count_value, 32'h52, "point two no load");
    chk(32'(o_match_out), 32'h3, "both outputs");
    chk(32'(rise_1), 32'h1, "load two turned on");
    chk(ev_1, 2, "event two");
    tdone("preset on match");
    @(posedge i_ref_clk);
    i_index_preset_set <= 1'b1;
    @(posedge i_ref_clk);
    i_index_preset_set <= 1'b0;
    wt(3);
    chk(32'(o_status[6]), 32'h1, "index flag set");
    wr(CPMO_ADDR_CTRL, 32'h59);
    wt(4);
    chk(o_count_value, 32'h52, "preset blocked");
    wr(CPMO_ADDR_CTRL, 32'h78);
    wr(CPMO_ADDR_CTRL, 32'h58);
    wr(CPMO_ADDR_CTRL, 32'h59);
    wt(4);
    chk(o_count_value, 32'h50, "preset after flag clear");
    chk(32'(o_status[6]), 32'h0, "index flag cleared");
    tdone("index block");
    sat(32'h80000000, 1'b0, 6'h24);
    sat(32'h7fffffff, 1'b1, 6'h09);
    tdone("limits");
    complete_run();
  end
endmodule : cpmo_core_tb
`default_nettype wire

// file: cpmo_load.sv
// Model of the external loads switched by the two match outputs.
`timescale 1ns/1ps
`default_nettype none
module cpmo_load (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [1:0] i_match_out,
  output logic [7:0] o_rise_0,
  output logic [7:0] o_rise_1
);
  logic [1:0] last_reg;
  // ****************************************
  // Load switching
  // ****************************************
  // Counts each turn-on of a load, as a relay on the pin would see it.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_reg <= 2'h0;
      o_rise_0 <= 8'h00;
      o_rise_1 <= 8'h00;
    end else begin
      last_reg <= i_match_out;
      if (i_match_out[0] && !last_reg[0]) begin
        o_rise_0 <= o_rise_0 + 8'h01;
      end
      if (i_match_out[1] && !last_reg[1]) begin
        o_rise_1 <= o_rise_1 + 8'h01;
      end
    end
  end
endmodule : cpmo_load
`default_nettype wire

// file: cpmo_pkg.sv
// Constants, register map and carrier types of the preset and match block.
package cpmo_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int CPMO_AW = 8;
  localparam logic [7:0] CPMO_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CPMO_ADDR_PRESET = 8'h04;
  localparam logic [7:0] CPMO_ADDR_MATCH1 = 8'h08;
  localparam logic [7:0] CPMO_ADDR_MATCH2 = 8'h0c;
  localparam logic [7:0] CPMO_ADDR_CNT_LO = 8'h10;
  localparam logic [7:0] CPMO_ADDR_CNT_HI = 8'h14;
  localparam logic [7:0] CPMO_ADDR_STATUS = 8'h18;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam int CPMO_CTRL_W = 7;
  localparam logic [6:0] CPMO_CTRL_RST = 7'h00;
  localparam logic [31:0] CPMO_WORD_RST = 32'h00000000;
  localparam logic signed [31:0] CPMO_CNT_MAX = 32'sh7fffffff;
  localparam logic signed [31:0] CPMO_CNT_MIN = 32'sh80000000;
  localparam logic signed [31:0] CPMO_CNT_ONE = 32'sh00000001;

  // Control word, bit 0 is the preset command.
  typedef struct packed {
    logic preset_on_match;
    logic ext_index_preset_flag_clear;
    logic count_enable_cmd;
    logic match_output_enable_cmd;
    logic match_clear_cmd_2;
    logic match_clear_cmd_1;
    logic preset_cmd;
  } cpmo_ctrl_t;

  // Comparison flags of one match point, bit 0 is above.
  typedef struct packed {
    logic below;
    logic match;
    logic above;
  } cpmo_cmp_t;

  // Status word: point 1 in bits 2..0, point 2 in 5..3, index flag bit 6.
  typedef struct packed {
    logic ext_index_preset_flag;
    cpmo_cmp_t pt2;
    cpmo_cmp_t pt1;
  } cpmo_status_t;

endpackage : cpmo_pkg
